// ==== logic/pcnt_dual_pulse_counter.sv ====
/*
 * Dual 16-bit pulse counter with optional 32-bit chaining, reference-pass
 * detection, sticky status and a maskable interrupt / wake-up output.
 * Assumes one 200 MHz clock, a plain register port, and a 32 kHz clock that
 * arrives asynchronously and is treated as a sampled input.
 */
`timescale 1ns/1ps
module pcnt_dual_pulse_counter
   import pcnt_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic       [DATA_W-1:0] o_rdata,
   input  wire logic              i_counter0_input_pin,
   input  wire logic              i_counter1_input_pin,
   input  wire logic              i_lp_clk,
   input  wire logic              i_sleep,
   output logic                   o_irq,
   output logic                   o_wake,
   output logic       [1:0]       o_system_controller_irq_source
);

   // ==========================================================================
   // Register decode
   // ==========================================================================
   logic wr_cmd;
   logic wr_cfg0;
   logic wr_cfg1;
   logic wr_status;
   logic wr_istat;
   logic start0;
   logic start1;
   logic stop0;
   logic stop1;

   assign wr_cmd    = i_wr && (i_addr == ADDR_CMD);
   assign wr_cfg0   = i_wr && (i_addr == ADDR_CFG0);
   assign wr_cfg1   = i_wr && (i_addr == ADDR_CFG1);
   assign wr_status = i_wr && (i_addr == ADDR_STATUS);
   assign wr_istat  = i_wr && (i_addr == ADDR_IRQ_STAT);
   assign start0    = wr_cmd && i_wdata[CMD_START0];
   assign start1    = wr_cmd && i_wdata[CMD_START1];
   assign stop0     = wr_cmd && i_wdata[CMD_STOP0];
   assign stop1     = wr_cmd && i_wdata[CMD_STOP1];

   // ==========================================================================
   // Configuration and reference registers
   // ==========================================================================
   pcnt_cfg_t         cfg0_reg;
   pcnt_cfg_t         cfg1_reg;
   logic [CNT_W-1:0]  ref0_reg;
   logic [CNT_W-1:0]  ref1_reg;
   logic [1:0]        mask_reg;
   logic              comb;

   assign comb = cfg0_reg.combine;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cfg0_reg <= CFG_RST;
         cfg1_reg <= CFG_RST;
      end else begin
         if (wr_cfg0) cfg0_reg <= pcnt_cfg_t'(i_wdata[CFG_W-1:0]);
         // Only counter zero's configuration holds the chaining option
         if (wr_cfg1) cfg1_reg <= pcnt_cfg_t'({1'b0, i_wdata[CFG_W-2:0]});
      end
   end

   // References update at any time; comparison simply uses the new value
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ref0_reg <= REF_RST;
         ref1_reg <= REF_RST;
         mask_reg <= MASK_RST;
      end else begin
         if (i_wr && (i_addr == ADDR_REF0)) ref0_reg <= i_wdata[CNT_W-1:0];
         if (i_wr && (i_addr == ADDR_REF1)) ref1_reg <= i_wdata[CNT_W-1:0];
         if (i_wr && (i_addr == ADDR_IRQ_MASK)) mask_reg <= i_wdata[1:0];
      end
   end

   // ==========================================================================
   // Input conditioning, one instance per pin
   // ==========================================================================
   logic edge0;
   logic edge1;

   pcnt_input_cond u_cond0 (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_pin     (i_counter0_input_pin),
      .i_lp_clk  (i_lp_clk),
      .i_falling (cfg0_reg.falling),
      .i_dbnc    (cfg0_reg.dbnc),
      .o_edge    (edge0)
   );

   pcnt_input_cond u_cond1 (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_pin     (i_counter1_input_pin),
      .i_lp_clk  (i_lp_clk),
      .i_falling (cfg1_reg.falling),
      .i_dbnc    (cfg1_reg.dbnc),
      .o_edge    (edge1)
   );

   // ==========================================================================
   // Run control
   // ==========================================================================
   logic run0_reg;
   logic run1_reg;
   logic act1;

   // Edge tracking runs while stopped, so a start never fabricates a count
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         run0_reg <= 1'b0;
         run1_reg <= 1'b0;
      end else begin
         if (start0) run0_reg <= 1'b1;
         else if (stop0) run0_reg <= 1'b0;
         if (start1) run1_reg <= 1'b1;
         else if (stop1) run1_reg <= 1'b0;
      end
   end

   // In chained mode the upper half follows counter zero's run state
   assign act1 = comb ? run0_reg : run1_reg;

   // ==========================================================================
   // Counters
   // ==========================================================================
   logic [CNT_W-1:0] cnt0_reg;
   logic [CNT_W-1:0] cnt1_reg;
   logic             inc0;
   logic             inc1;
   logic             clr0;
   logic             clr1;

   // Sleep does not gate counting; i_sleep only chooses between o_irq and o_wake
   assign inc0 = run0_reg && edge0;
   assign inc1 = comb ? (inc0 && (cnt0_reg == '1)) : (run1_reg && edge1);
   assign clr0 = wr_cmd && !run0_reg
                 && (i_wdata[CMD_CLR0] || (comb && i_wdata[CMD_CLR32]));
   assign clr1 = wr_cmd && !act1
                 && (i_wdata[CMD_CLR1] || (comb && i_wdata[CMD_CLR32]));

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt0_reg <= '0;
      end else if (clr0) begin
         cnt0_reg <= '0;
      end else if (inc0) begin
         cnt0_reg <= cnt0_reg + 16'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt1_reg <= '0;
      end else if (clr1) begin
         cnt1_reg <= '0;
      end else if (inc1) begin
         cnt1_reg <= cnt1_reg + 16'h1;
      end
   end

   // ==========================================================================
   // Reference pass detection
   // ==========================================================================
   logic pass0;
   logic pass1;

   // Incrementing from the reference value lands on reference plus one;
   // nothing reloads afterwards, counting simply continues
   assign pass0 = inc0 && (comb ? ({cnt1_reg, cnt0_reg} == {ref1_reg, ref0_reg})
                                : (cnt0_reg == ref0_reg));
   assign pass1 = !comb && inc1 && (cnt1_reg == ref1_reg);

   // ==========================================================================
   // Sticky reached flags
   // ==========================================================================
   logic reach0_reg;
   logic reach1_reg;

   // Set wins over any clear in the same cycle so a poll cannot miss it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         reach0_reg <= 1'b0;
         reach1_reg <= 1'b0;
      end else begin
         if (pass0) reach0_reg <= 1'b1;
         else if ((wr_status && i_wdata[ST_REACH0]) || clr0 || wr_cfg0) reach0_reg <= 1'b0;
         if (pass1) reach1_reg <= 1'b1;
         else if ((wr_status && i_wdata[ST_REACH1]) || clr1 || wr_cfg1) reach1_reg <= 1'b0;
      end
   end

   // ==========================================================================
   // Interrupt status, mask and outputs
   // ==========================================================================
   logic [1:0] istat_reg;
   logic [1:0] ievt;
   logic       pend;

   // Chained counter reports through bit zero, pass1 is idle then
   assign ievt = {pass1 && cfg1_reg.irq_en, pass0 && cfg0_reg.irq_en};
   assign pend = |(istat_reg & mask_reg);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         istat_reg <= 2'h0;
      end else begin
         istat_reg <= ievt | (istat_reg & ~(wr_istat ? i_wdata[1:0] : 2'h0));
      end
   end

   // A pending event wakes a sleeping device and interrupts an awake one
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_irq                          <= 1'b0;
         o_wake                         <= 1'b0;
         o_system_controller_irq_source <= 2'h0;
      end else begin
         o_irq                          <= pend && !i_sleep;
         o_wake                         <= pend && i_sleep;
         o_system_controller_irq_source <= istat_reg & mask_reg;
      end
   end

   // ==========================================================================
   // Read port: data valid in the cycle after the strobe
   // ==========================================================================
   logic [DATA_W-1:0] rd_mux;
   logic [3:0]        status;

   assign status = {reach1_reg, reach0_reg, run1_reg && !comb, run0_reg};

   always_comb begin
      unique case (i_addr)
         ADDR_CFG0:     rd_mux = {27'h0, cfg0_reg};
         ADDR_CFG1:     rd_mux = {27'h0, cfg1_reg};
         ADDR_REF0:     rd_mux = {16'h0, ref0_reg};
         ADDR_REF1:     rd_mux = {16'h0, ref1_reg};
         ADDR_COUNT0:   rd_mux = {16'h0, cnt0_reg};
         ADDR_COUNT1:   rd_mux = {16'h0, cnt1_reg};
         ADDR_COUNT32:  rd_mux = {cnt1_reg, cnt0_reg};
         ADDR_STATUS:   rd_mux = {28'h0, status};
         ADDR_IRQ_STAT: rd_mux = {30'h0, istat_reg};
         ADDR_IRQ_MASK: rd_mux = {30'h0, mask_reg};
         default:       rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rdata <= 32'h0;
      end else begin
         o_rdata <= i_rd ? rd_mux : 32'h0;
      end
   end

endmodule // pcnt_dual_pulse_counter

// ==== logic/pcnt_pkg.sv ====
/*
 * Package for the dual pulse counter: register map, field layout, reset values
 * and debounce settings shared by the counter core and its input conditioner.
 * Assumes a 200 MHz system clock and a free-running 32 kHz low-power clock.
 */
package pcnt_pkg;

   // ==========================================================================
   // Register bus
   // ==========================================================================
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W  = 16;

   localparam logic [7:0] ADDR_CMD       = 8'h00;
   localparam logic [7:0] ADDR_CFG0      = 8'h04;
   localparam logic [7:0] ADDR_CFG1      = 8'h08;
   localparam logic [7:0] ADDR_REF0      = 8'h0c;
   localparam logic [7:0] ADDR_REF1      = 8'h10;
   localparam logic [7:0] ADDR_COUNT0    = 8'h14;
   localparam logic [7:0] ADDR_COUNT1    = 8'h18;
   localparam logic [7:0] ADDR_COUNT32   = 8'h1c;
   localparam logic [7:0] ADDR_STATUS    = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h24;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h28;

   // ==========================================================================
   // Command register bits (write-only, self-clearing)
   // ==========================================================================
   localparam int unsigned CMD_START0 = 0;
   localparam int unsigned CMD_START1 = 1;
   localparam int unsigned CMD_STOP0  = 2;
   localparam int unsigned CMD_STOP1  = 3;
   localparam int unsigned CMD_CLR0   = 4;
   localparam int unsigned CMD_CLR1   = 5;
   localparam int unsigned CMD_CLR32  = 6;

   // ==========================================================================
   // Status register bits
   // ==========================================================================
   localparam int unsigned ST_RUN0   = 0;
   localparam int unsigned ST_RUN1   = 1;
   localparam int unsigned ST_REACH0 = 2;
   localparam int unsigned ST_REACH1 = 3;

   // ==========================================================================
   // Configuration layout and reset values
   // ==========================================================================
   typedef enum logic [1:0] {
      PCNT_DB_OFF,
      PCNT_DB_2,
      PCNT_DB_4,
      PCNT_DB_8
   } pcnt_dbnc_t;

   // Bit 0 falling edge, bits 2:1 debounce, bit 3 irq enable, bit 4 combine
   typedef struct packed {
      logic       combine;
      logic       irq_en;
      pcnt_dbnc_t dbnc;
      logic       falling;
   } pcnt_cfg_t;

   localparam int unsigned CFG_W = 5;
   localparam pcnt_cfg_t   CFG_RST = '{combine: 1'b0, irq_en: 1'b0,
                                       dbnc: PCNT_DB_OFF, falling: 1'b0};
   localparam logic [15:0] REF_RST  = 16'h0000;
   localparam logic [1:0]  MASK_RST = 2'h0;

   // ==========================================================================
   // Debounce sample counts, in 32 kHz ticks
   // ==========================================================================
   localparam logic [3:0] DB_SAMPLES_2 = 4'h2;
   localparam logic [3:0] DB_SAMPLES_4 = 4'h4;
   localparam logic [3:0] DB_SAMPLES_8 = 4'h8;

endpackage

// ==== logic/pcnt_input_cond.sv ====
/*
 * Input conditioner for one pulse counter: synchronises the input pin and the
 * 32 kHz clock, optionally debounces, and emits a one-cycle count pulse on the
 * selected edge. Assumes i_pin and i_lp_clk are asynchronous to i_clk.
 */
`timescale 1ns/1ps
module pcnt_input_cond
   import pcnt_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_pin,
   input  wire logic       i_lp_clk,
   input  wire logic       i_falling,
   input  wire pcnt_dbnc_t i_dbnc,
   output logic            o_edge
);

   // ==========================================================================
   // Synchronisers: a change counts once stages two and three agree
   // ==========================================================================
   logic [2:0] pin_sync_reg;
   logic [2:0] lpc_sync_reg;
   logic       raw_reg;
   logic       lpc_reg;
   logic       lpc_prev_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_sync_reg <= 3'h0;
         lpc_sync_reg <= 3'h0;
         raw_reg      <= 1'b0;
         lpc_reg      <= 1'b0;
         lpc_prev_reg <= 1'b0;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], i_pin};
         lpc_sync_reg <= {lpc_sync_reg[1:0], i_lp_clk};
         if (pin_sync_reg[1] == pin_sync_reg[2]) raw_reg <= pin_sync_reg[2];
         if (lpc_sync_reg[1] == lpc_sync_reg[2]) lpc_reg <= lpc_sync_reg[2];
         lpc_prev_reg <= lpc_reg;
      end
   end

   // ==========================================================================
   // Debounce on the 32 kHz tick
   // ==========================================================================
   logic       tick;
   logic [3:0] need;
   logic [3:0] run_reg;
   logic       filt_reg;

   assign tick = lpc_reg & ~lpc_prev_reg;

   // Sample count sets the highest input rate the filter passes
   always_comb begin
      unique case (i_dbnc)
         PCNT_DB_2: need = DB_SAMPLES_2;
         PCNT_DB_4: need = DB_SAMPLES_4;
         PCNT_DB_8: need = DB_SAMPLES_8;
         PCNT_DB_OFF: need = DB_SAMPLES_2;
      endcase
   end

   // With debounce off the filter tracks the raw level so enabling it later
   // cannot produce a phantom edge
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         filt_reg <= 1'b0;
         run_reg  <= 4'h0;
      end else if (i_dbnc == PCNT_DB_OFF) begin
         filt_reg <= raw_reg;
         run_reg  <= 4'h0;
      end else if (tick) begin
         if (raw_reg == filt_reg) begin
            run_reg <= 4'h0;
         end else if (run_reg + 4'h1 == need) begin
            filt_reg <= raw_reg;
            run_reg  <= 4'h0;
         end else begin
            run_reg <= run_reg + 4'h1;
         end
      end
   end

   // ==========================================================================
   // Edge selection
   // ==========================================================================
   logic lvl;
   logic lvl_prev_reg;

   assign lvl = (i_dbnc == PCNT_DB_OFF) ? raw_reg : filt_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lvl_prev_reg <= 1'b0;
         o_edge       <= 1'b0;
      end else begin
         lvl_prev_reg <= lvl;
         o_edge       <= (lvl != lvl_prev_reg) && (lvl == ~i_falling);
      end
   end

endmodule // pcnt_input_cond

// ==== tb/pcnt_monitor.sv ====
/* Port-level checker for the dual pulse counter.
   Assumes it is bound onto pcnt_dual_pulse_counter: one clock, sync reset. */
`timescale 1ns/1ps
module pcnt_monitor
   import pcnt_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic              i_sleep,
   input wire logic              o_irq,
   input wire logic              o_wake,
   input wire logic [1:0]        o_system_controller_irq_source
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==========================================================================
   // Command and status steps
   // ==========================================================================
   sequence s_start0;
      i_wr && i_addr == ADDR_CMD && i_wdata[CMD_START0];
   endsequence
   sequence s_stop0;
      i_wr && i_addr == ADDR_CMD && i_wdata[CMD_STOP0] && !i_wdata[CMD_START0];
   endsequence
   sequence s_rd_status;
      i_rd && i_addr == ADDR_STATUS;
   endsequence
   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data not zero outside read answer");
   a_unmapped_zero: assert property (i_rd && i_addr == 8'hfc |=> o_rdata == '0)
      else $error("unmapped read gave data");
   a_start_status: assert property (s_start0 ##1 !i_wr ##1 s_rd_status |=> o_rdata[ST_RUN0])
      else $error("run flag missing after start");
   a_stop_status: assert property (s_stop0 ##1 !i_wr ##1 s_rd_status |=> !o_rdata[ST_RUN0])
      else $error("run flag still set after stop");
   a_irq_awake: assert property (o_irq |-> !$past(i_sleep))
      else $error("interrupt raised while asleep");
   a_wake_asleep: assert property (o_wake |-> $past(i_sleep))
      else $error("wake raised while awake");
   a_src_level: assert property ((|o_system_controller_irq_source) == (o_irq || o_wake))
      else $error("source bitmap and interrupt disagree");
   a_src_sticky: assert property ($fell(|o_system_controller_irq_source)
      |-> $past(i_wr) || $past(i_wr, 2))
      else $error("interrupt source dropped without a write");
endmodule // pcnt_monitor

// ==== tb/pcnt_pulse_src.sv ====
/* Pulse source model: drives both counter pins and the low-power clock.
   Assumes the caller starts each level change from a clock edge. */
`timescale 1ns/1ps
module pcnt_pulse_src (
   input  wire logic i_clk,
   output logic      o_pin0,
   output logic      o_pin1,
   output logic      o_lp_clk
);
   // Levels are far shorter than the documented rate to keep the run short,
   // yet above the minimum width the conditioner needs with debounce off
   localparam int HOLD = 10;
   initial begin
      o_pin0   = 1'b0;
      o_pin1   = 1'b0;
      o_lp_clk = 1'b0;
   end
   // ==========================================================================
   // Low-power clock runs free, as debounce needs it alive
   // ==========================================================================
   // Sped up far beyond 32 kHz so debounce runs in a short test; still slow
   // enough for the three-stage sampler to see every level
   always #100 o_lp_clk = ~o_lp_clk;
   task automatic set_pin(input int ch, input logic v);
      @(posedge i_clk);
      if (ch == 0) begin
         o_pin0 <= v;
      end else begin
         o_pin1 <= v;
      end
      repeat (HOLD) @(posedge i_clk);
   endtask
   task automatic pulse(input int ch, input int n);
      repeat (n) begin
         set_pin(ch, 1'b1);
         set_pin(ch, 1'b0);
      end
   endtask
endmodule // pcnt_pulse_src

// ==== tb/pcnt_dual_pulse_counter_tb.sv ====
/* Self-checking bench for the dual pulse counter over its register port.
   Assumes the pulse source model drives the pins and the low-power clock. */
`timescale 1ns/1ps
module pcnt_dual_pulse_counter_tb
   import pcnt_pkg::*;
;
   logic        i_clk;
   logic        i_rst;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [31:0] o_rdata;
   logic        i_sleep;
   logic        o_irq;
   logic        o_wake;
   logic [1:0]  o_src;
   logic        pin0;
   logic        pin1;
   logic        lp_clk;
   int          errors;
   int          n_tests;
   int          cycles;

   pcnt_pulse_src u_src (.i_clk(i_clk), .o_pin0(pin0), .o_pin1(pin1), .o_lp_clk(lp_clk));
   pcnt_dual_pulse_counter dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_counter0_input_pin(pin0), .i_counter1_input_pin(pin1),
      .i_lp_clk(lp_clk), .i_sleep(i_sleep), .o_irq(o_irq), .o_wake(o_wake),
      .o_system_controller_irq_source(o_src));
   // ==========================================================================
   // Clock, timeout and report
   // ==========================================================================
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Whole sequence needs about 550 cycles
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         errors++;
         final_report();
      end
   end
   // ==========================================================================
   // Register port tasks and compares
   // ==========================================================================
   task automatic chk_reg(input logic [31:0] act, input logic [31:0] exp);
      n_tests++;
      if (act !== exp) begin
         errors++;
         $display("Error at %0t: register got %h expected %h", $time, act, exp);
      end
   endtask
   task automatic chk_out(input logic [1:0] act, input logic [1:0] exp);
      n_tests++;
      if (act !== exp) begin
         errors++;
         $display("Error at %0t: output got %h expected %h", $time, act, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      chk_reg(o_rdata, exp);
   endtask
   // ==========================================================================
   // Test sequence
   // ==========================================================================
   initial begin
      i_rst = 1'b1; i_addr = 8'h00; i_wdata = 32'h0; i_wr = 1'b0; i_rd = 1'b0;
      i_sleep = 1'b0; errors = 0; n_tests = 0; cycles = 0;
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(ADDR_CFG0, 32'h0);
      rd(ADDR_REF0, 32'h0);
      rd(ADDR_IRQ_MASK, 32'h0);
      rd(ADDR_STATUS, 32'h0);
      rd(8'hfc, 32'h0);
      // Counter 0: rising edge, reference pass, interrupt
      wr(ADDR_CFG0, 32'h8);
      wr(ADDR_REF0, 32'h2);
      wr(ADDR_IRQ_MASK, 32'h3);
      wr(ADDR_CMD, 32'h1);
      rd(ADDR_STATUS, 32'h1);
      u_src.pulse(0, 2);
      rd(ADDR_COUNT0, 32'h2);
      rd(ADDR_STATUS, 32'h1);
      u_src.pulse(0, 1);
      rd(ADDR_COUNT0, 32'h3);
      rd(ADDR_STATUS, 32'h5);
      chk_out({o_wake, o_irq}, 2'b01);
      chk_out(o_src, 2'b01);
      wr(ADDR_REF0, 32'h5);
      u_src.pulse(0, 1);
      rd(ADDR_COUNT0, 32'h4);
      wr(ADDR_IRQ_STAT, 32'h1);
      rd(ADDR_STATUS, 32'h5);
      chk_out({o_wake, o_irq}, 2'b00);
      // Clear refused while running, honoured after stop
      wr(ADDR_CMD, 32'h10);
      rd(ADDR_COUNT0, 32'h4);
      wr(ADDR_CMD, 32'h4);
      rd(ADDR_STATUS, 32'h4);
      u_src.pulse(0, 2);
      rd(ADDR_COUNT0, 32'h4);
      rd(ADDR_STATUS, 32'h4);
      wr(ADDR_CMD, 32'h10);
      rd(ADDR_COUNT0, 32'h0);
      // Counter 1: falling edge, pass while asleep
      wr(ADDR_CFG1, 32'h9);
      wr(ADDR_CMD, 32'h2);
      @(posedge i_clk);
      i_sleep <= 1'b1;
      u_src.set_pin(1, 1'b1);
      rd(ADDR_COUNT1, 32'h0);
      u_src.set_pin(1, 1'b0);
      rd(ADDR_COUNT1, 32'h1);
      rd(ADDR_STATUS, 32'ha);
      chk_out({o_wake, o_irq}, 2'b10);
      chk_out(o_src, 2'b10);
      @(posedge i_clk);
      i_sleep <= 1'b0;
      wr(ADDR_IRQ_STAT, 32'h3);
      // Combined 32-bit counter fed from pin zero only
      wr(ADDR_CMD, 32'h8);
      wr(ADDR_CMD, 32'h20);
      wr(ADDR_CFG0, 32'h18);
      wr(ADDR_REF0, 32'h0);
      wr(ADDR_REF1, 32'h0);
      wr(ADDR_CMD, 32'h1);
      u_src.pulse(1, 1);
      u_src.pulse(0, 1);
      rd(ADDR_COUNT32, 32'h1);
      rd(ADDR_COUNT1, 32'h0);
      chk_out(o_src, 2'b01);
      wr(ADDR_CMD, 32'h4);
      wr(ADDR_CMD, 32'h40);
      rd(ADDR_COUNT32, 32'h0);
      // Counter 1 with two-sample debounce: a short glitch is dropped
      wr(ADDR_CFG0, 32'h0);
      wr(ADDR_CFG1, 32'h2);
      wr(ADDR_CMD, 32'h2);
      u_src.pulse(1, 1);
      rd(ADDR_COUNT1, 32'h0);
      u_src.set_pin(1, 1'b1);
      repeat (100) @(posedge i_clk);
      u_src.set_pin(1, 1'b0);
      repeat (100) @(posedge i_clk);
      rd(ADDR_COUNT1, 32'h1);
      // Reset in mid-run returns configuration to defaults
      @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(ADDR_CFG0, 32'h0);
      final_report();
   end
endmodule // pcnt_dual_pulse_counter_tb

bind pcnt_dual_pulse_counter pcnt_monitor u_mon (
   .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep), .o_irq(o_irq), .o_wake(o_wake),
   .o_system_controller_irq_source(o_system_controller_irq_source));
